// file: logic/rtcc_map.svh
`ifndef RTCC_MAP_SVH
`define RTCC_MAP_SVH

// byte addresses of the register window
`define RTCC_OFS_HOUR        12'h000
`define RTCC_OFS_WEEKDAY     12'h004
`define RTCC_OFS_DATE        12'h008
`define RTCC_OFS_MONTH       12'h00c
`define RTCC_OFS_PAGE_CTRL   12'h010

// field widths
`define RTCC_HOUR_W          6
`define RTCC_WEEKDAY_W       3
`define RTCC_DATE_W          6
`define RTCC_MONTH_W         5

// page control bit positions
`define RTCC_PAGE_BIT        0
`define RTCC_ENABLE_BIT      3

// reset values of control state
`define RTCC_PAGE_RST        1'b0
`define RTCC_ENABLE_RST      1'b0
`define RTCC_FORMAT_RST      1'b1

// hour encodings
`define RTCC_HOUR24_LAST     6'h23
`define RTCC_HOUR12_LAST     5'h11
`define RTCC_HOUR12_PM_BIT   5

// calendar encodings
`define RTCC_WEEKDAY_LAST    3'h6
`define RTCC_DATE_FIRST      6'h01
`define RTCC_MONTH_FIRST     5'h01
`define RTCC_MONTH_LAST      5'h12
`define RTCC_MONTH_FEB       5'h02
`define RTCC_MONTH_APR       5'h04
`define RTCC_MONTH_JUN       5'h06
`define RTCC_MONTH_SEP       5'h09
`define RTCC_MONTH_NOV       5'h11
`define RTCC_DAYS_FEB_LEAP   6'h29
`define RTCC_DAYS_FEB        6'h28
`define RTCC_DAYS_SHORT      6'h30
`define RTCC_DAYS_LONG       6'h31

// axi responses
`define RTCC_RESP_OKAY       2'b00
`define RTCC_RESP_SLVERR     2'b10

`endif

// file: logic/rtcc_pkg.sv
`default_nettype none
package rtcc_pkg;

  typedef struct packed {
    logic [5:0] hour;
    logic [2:0] weekday;
    logic [5:0] date;
    logic [4:0] month;
  } rtcc_cal_t;

  typedef struct packed {
    logic [5:0] hour;
    logic [2:0] weekday;
    logic [5:0] date;
  } rtcc_alarm_t;

  typedef struct packed {
    logic        en;
    logic [11:0] addr;
    logic [31:0] data;
    logic [3:0]  strb;
  } rtcc_wr_t;

endpackage : rtcc_pkg
`default_nettype wire

// file: logic/rtcc_axil_slave.sv
`timescale 1ns/1ns
`default_nettype none
`include "rtcc_map.svh"
module rtcc_axil_slave
  import rtcc_pkg::*;
(
  input  wire logic        i_clk,
  input  wire logic        i_arst_n,
  input  wire logic [11:0] i_awaddr,
  input  wire logic        i_awvalid,
  output var  logic        o_awready,
  input  wire logic [31:0] i_wdata,
  input  wire logic [3:0]  i_wstrb,
  input  wire logic        i_wvalid,
  output var  logic        o_wready,
  output var  logic [1:0]  o_bresp,
  output var  logic        o_bvalid,
  input  wire logic        i_bready,
  input  wire logic [11:0] i_araddr,
  input  wire logic        i_arvalid,
  output var  logic        o_arready,
  output var  logic [31:0] o_rdata,
  output var  logic [1:0]  o_rresp,
  output var  logic        o_rvalid,
  input  wire logic        i_rready,
  output var  rtcc_wr_t    o_wr,
  input  wire logic        i_wr_err,
  output var  logic        o_rd_en,
  output var  logic [11:0] o_rd_addr,
  input  wire logic [31:0] i_rd_data,
  input  wire logic        i_rd_err
);

  logic        aw_full_reg, aw_full_next;
  logic        w_full_reg, w_full_next;
  logic [11:0] awaddr_reg, awaddr_next;
  logic [31:0] wdata_reg, wdata_next;
  logic [3:0]  wstrb_reg, wstrb_next;
  logic        bvalid_reg, bvalid_next;
  logic [1:0]  bresp_reg, bresp_next;
  logic        rvalid_reg, rvalid_next;
  logic [1:0]  rresp_reg, rresp_next;
  logic [31:0] rdata_reg, rdata_next;
  logic        wr_go;
  logic        awready_reg, awready_next;
  logic        wready_reg, wready_next;
  logic        arready_reg, arready_next;

  // write is issued once both halves are held and no response is pending
  assign wr_go       = aw_full_reg & w_full_reg & ~bvalid_reg;
  assign o_wr        = '{en: wr_go, addr: awaddr_reg, data: wdata_reg, strb: wstrb_reg};
  assign o_rd_en     = i_arvalid & ~rvalid_reg;
  assign o_rd_addr   = i_araddr;
  assign o_awready   = awready_reg;
  assign o_wready    = wready_reg;
  assign o_arready   = arready_reg;
  assign o_bvalid    = bvalid_reg;
  assign o_bresp     = bresp_reg;
  assign o_rvalid    = rvalid_reg;
  assign o_rresp     = rresp_reg;
  assign o_rdata     = rdata_reg;

  always_comb begin
    aw_full_next = aw_full_reg;
    w_full_next  = w_full_reg;
    awaddr_next  = awaddr_reg;
    wdata_next   = wdata_reg;
    wstrb_next   = wstrb_reg;
    bvalid_next  = bvalid_reg;
    bresp_next   = bresp_reg;
    rvalid_next  = rvalid_reg;
    rresp_next   = rresp_reg;
    rdata_next   = rdata_reg;
    if (i_awvalid && !aw_full_reg) begin
      aw_full_next = 1'b1;
      awaddr_next  = i_awaddr;
    end
    if (i_wvalid && !w_full_reg) begin
      w_full_next = 1'b1;
      wdata_next  = i_wdata;
      wstrb_next  = i_wstrb;
    end
    if (wr_go) begin
      aw_full_next = 1'b0;
      w_full_next  = 1'b0;
      bvalid_next  = 1'b1;
      bresp_next   = i_wr_err ? `RTCC_RESP_SLVERR : `RTCC_RESP_OKAY;
    end else if (bvalid_reg && i_bready) begin
      bvalid_next = 1'b0;
    end
    if (o_rd_en) begin
      rvalid_next = 1'b1;
      rdata_next  = i_rd_data;
      rresp_next  = i_rd_err ? `RTCC_RESP_SLVERR : `RTCC_RESP_OKAY;
    end else if (rvalid_reg && i_rready) begin
      rvalid_next = 1'b0;
    end
    // ready flags kept in flops so the ports need no gate after them
    awready_next = ~aw_full_next;
    wready_next  = ~w_full_next;
    arready_next = ~rvalid_next;
  end

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      aw_full_reg <= 1'b0;
      w_full_reg  <= 1'b0;
      awaddr_reg  <= 12'h000;
      wdata_reg   <= 32'h0000_0000;
      wstrb_reg   <= 4'h0;
      bvalid_reg  <= 1'b0;
      bresp_reg   <= 2'h0;
      rvalid_reg  <= 1'b0;
      rresp_reg   <= 2'h0;
      rdata_reg   <= 32'h0000_0000;
      awready_reg <= 1'b1;
      wready_reg  <= 1'b1;
      arready_reg <= 1'b1;
    end else begin
      aw_full_reg <= aw_full_next;
      w_full_reg  <= w_full_next;
      awaddr_reg  <= awaddr_next;
      wdata_reg   <= wdata_next;
      wstrb_reg   <= wstrb_next;
      bvalid_reg  <= bvalid_next;
      bresp_reg   <= bresp_next;
      rvalid_reg  <= rvalid_next;
      rresp_reg   <= rresp_next;
      rdata_reg   <= rdata_next;
      awready_reg <= awready_next;
      wready_reg  <= wready_next;
      arready_reg <= arready_next;
    end
  end

endmodule : rtcc_axil_slave
`default_nettype wire

// file: logic/rtcc_cal_step.sv
`timescale 1ns/1ns
`default_nettype none
`include "rtcc_map.svh"
module rtcc_cal_step
  import rtcc_pkg::*;
(
  input  wire logic      i_fmt_24h,
  input  wire logic      i_leap_year,
  input  wire rtcc_cal_t i_cal,
  output var  rtcc_cal_t o_cal
);

  function automatic logic [5:0] bcd_inc(input logic [5:0] v);
    if (v[3:0] == 4'h9) begin
      bcd_inc = {v[5:4] + 2'h1, 4'h0};
    end else begin
      bcd_inc = {v[5:4], v[3:0] + 4'h1};
    end
  endfunction : bcd_inc

  logic       day_carry;
  logic [5:0] month_days;
  logic [5:0] month_inc;
  logic [5:0] hour12_inc;

  assign month_inc  = bcd_inc({1'b0, i_cal.month});
  assign hour12_inc = bcd_inc({1'b0, i_cal.hour[4:0]});

  always_comb begin
    o_cal     = i_cal;
    day_carry = 1'b0;
    if (i_fmt_24h) begin
      if (i_cal.hour == `RTCC_HOUR24_LAST) begin // RULE1
        o_cal.hour = 6'h00;
        day_carry  = 1'b1;
      end else begin
        o_cal.hour = bcd_inc(i_cal.hour); // RULE3
      end
    end else begin
      if (i_cal.hour[4:0] == `RTCC_HOUR12_LAST) begin // RULE2
        o_cal.hour = {~i_cal.hour[`RTCC_HOUR12_PM_BIT], 5'h00};
        day_carry  = i_cal.hour[`RTCC_HOUR12_PM_BIT];
      end else begin
        o_cal.hour = {i_cal.hour[5], hour12_inc[4:0]}; // RULE2
      end
    end
    unique case (i_cal.month)
      `RTCC_MONTH_FEB: month_days = i_leap_year ? `RTCC_DAYS_FEB_LEAP : `RTCC_DAYS_FEB;
      `RTCC_MONTH_APR,
      `RTCC_MONTH_JUN,
      `RTCC_MONTH_SEP,
      `RTCC_MONTH_NOV: month_days = `RTCC_DAYS_SHORT;
      default:         month_days = `RTCC_DAYS_LONG;
    endcase
    if (day_carry) begin
      o_cal.weekday = (i_cal.weekday == `RTCC_WEEKDAY_LAST) ? 3'h0
                                                            : i_cal.weekday + 3'h1; // RULE4
      if (i_cal.date == month_days) begin // RULE6
        o_cal.date = `RTCC_DATE_FIRST;
        o_cal.month = (i_cal.month == `RTCC_MONTH_LAST) ? `RTCC_MONTH_FIRST
                                                        : month_inc[4:0]; // RULE8
      end else begin
        o_cal.date = bcd_inc(i_cal.date); // RULE6
      end
    end
  end

endmodule : rtcc_cal_step
`default_nettype wire

// file: logic/rtcc_top.sv
// Contract
// RULE1: 24-hour mode, BCD hours 00 to 23
// RULE2: format bit 0: PM flag, hours 00-11
// RULE3: format bit 1: bits 5:0 BCD hours
// RULE4: weekday 3-bit, Sunday 0 to Saturday 6
// RULE5: hour/weekday/date both pages; month/format share address
// RULE6: date BCD 01-31, bits 7:6 zero
// RULE7: software loads only existing, legal dates
// RULE8: page 0 month BCD 01-12, bits 7:5 zero
// RULE9: page 1 month address holds format bit
// RULE10: software changes format only while stopped
// RULE11: calendar fields start unpredictable after reset
//
// The AXI4-Lite register port and the address map were left to the implementer.
`timescale 1ns/1ns
`default_nettype none
`include "rtcc_map.svh"
module rtcc_top
  import rtcc_pkg::*;
(
  input  wire logic        i_clk,
  input  wire logic        i_arst_n,
  input  wire logic [11:0] i_awaddr,
  input  wire logic        i_awvalid,
  output var  logic        o_awready,
  input  wire logic [31:0] i_wdata,
  input  wire logic [3:0]  i_wstrb,
  input  wire logic        i_wvalid,
  output var  logic        o_wready,
  output var  logic [1:0]  o_bresp,
  output var  logic        o_bvalid,
  input  wire logic        i_bready,
  input  wire logic [11:0] i_araddr,
  input  wire logic        i_arvalid,
  output var  logic        o_arready,
  output var  logic [31:0] o_rdata,
  output var  logic [1:0]  o_rresp,
  output var  logic        o_rvalid,
  input  wire logic        i_rready,
  input  wire logic        i_hour_carry,
  input  wire logic        i_leap_year,
  output var  logic        o_alarm_hit
);

  rtcc_wr_t    wr;
  logic        wr_err;
  logic        rd_en;
  logic [11:0] rd_addr;
  logic [31:0] rd_data;
  logic        rd_err;

  rtcc_axil_slave u_bus (
    .i_clk     (i_clk),
    .i_arst_n  (i_arst_n),
    .i_awaddr  (i_awaddr),
    .i_awvalid (i_awvalid),
    .o_awready (o_awready),
    .i_wdata   (i_wdata),
    .i_wstrb   (i_wstrb),
    .i_wvalid  (i_wvalid),
    .o_wready  (o_wready),
    .o_bresp   (o_bresp),
    .o_bvalid  (o_bvalid),
    .i_bready  (i_bready),
    .i_araddr  (i_araddr),
    .i_arvalid (i_arvalid),
    .o_arready (o_arready),
    .o_rdata   (o_rdata),
    .o_rresp   (o_rresp),
    .o_rvalid  (o_rvalid),
    .i_rready  (i_rready),
    .o_wr      (wr),
    .i_wr_err  (wr_err),
    .o_rd_en   (rd_en),
    .o_rd_addr (rd_addr),
    .i_rd_data (rd_data),
    .i_rd_err  (rd_err)
  );

  function automatic logic addr_known(input logic [11:0] a);
    addr_known = (a == `RTCC_OFS_HOUR) || (a == `RTCC_OFS_WEEKDAY)
              || (a == `RTCC_OFS_DATE) || (a == `RTCC_OFS_MONTH)
              || (a == `RTCC_OFS_PAGE_CTRL);
  endfunction : addr_known

  // control state, defined after reset
  logic        page_reg, page_next;
  logic        enable_reg, enable_next;
  logic        fmt_24h_reg, fmt_24h_next;
  logic        alarm_hit_reg, alarm_hit_next;

  // calendar state, deliberately without reset
  rtcc_cal_t   cal_reg, cal_next;
  rtcc_alarm_t alarm_reg, alarm_next;
  rtcc_cal_t   cal_stepped;

  logic        wr_lane0;
  logic        wr_time_page;
  logic        wr_alarm_config_page;
  logic        tick;

  rtcc_cal_step u_step (
    .i_fmt_24h   (fmt_24h_reg),
    .i_leap_year (i_leap_year),
    .i_cal       (cal_reg),
    .o_cal       (cal_stepped)
  );

  assign wr_err   = ~addr_known(wr.addr);
  assign rd_err   = ~addr_known(rd_addr);
  assign wr_lane0 = wr.en & wr.strb[0];
  assign wr_time_page = wr_lane0 & ~page_reg;
  assign wr_alarm_config_page = wr_lane0 & page_reg;
  assign tick     = enable_reg & i_hour_carry;
  assign o_alarm_hit = alarm_hit_reg;

  // register read view, upper bits of each field read as zero
  always_comb begin
    rd_data = 32'h0000_0000;
    unique case (rd_addr)
      `RTCC_OFS_HOUR: begin
        rd_data[5:0] = page_reg ? alarm_reg.hour : cal_reg.hour; // RULE5
      end
      `RTCC_OFS_WEEKDAY: begin
        rd_data[2:0] = page_reg ? alarm_reg.weekday : cal_reg.weekday; // RULE4
      end
      `RTCC_OFS_DATE: begin
        rd_data[5:0] = page_reg ? alarm_reg.date : cal_reg.date; // RULE6
      end
      `RTCC_OFS_MONTH: begin
        if (page_reg) begin
          rd_data[0] = fmt_24h_reg; // RULE9
        end else begin
          rd_data[4:0] = cal_reg.month; // RULE8
        end
      end
      `RTCC_OFS_PAGE_CTRL: begin
        rd_data[`RTCC_PAGE_BIT]   = page_reg;
        rd_data[`RTCC_ENABLE_BIT] = enable_reg;
      end
      default: begin
        rd_data = 32'h0000_0000;
      end
    endcase
  end

  // control registers
  always_comb begin
    page_next    = page_reg;
    enable_next  = enable_reg;
    fmt_24h_next = fmt_24h_reg;
    if (wr_lane0 && wr.addr == `RTCC_OFS_PAGE_CTRL) begin
      page_next   = wr.data[`RTCC_PAGE_BIT];
      enable_next = wr.data[`RTCC_ENABLE_BIT];
    end
    // format is honoured whenever written; keeping it still while counting is software's job
    if (wr_alarm_config_page && wr.addr == `RTCC_OFS_MONTH) begin
      fmt_24h_next = wr.data[0]; // RULE9 RULE10
    end
  end

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      page_reg    <= `RTCC_PAGE_RST;
      enable_reg  <= `RTCC_ENABLE_RST;
      fmt_24h_reg <= `RTCC_FORMAT_RST;
    end else begin
      page_reg    <= page_next;
      enable_reg  <= enable_next;
      fmt_24h_reg <= fmt_24h_next;
    end
  end

  // time counting, a software write beats the count step on the same field
  always_comb begin
    cal_next   = tick ? cal_stepped : cal_reg;
    alarm_next = alarm_reg;
    if (wr_time_page) begin
      unique case (wr.addr)
        `RTCC_OFS_HOUR:    cal_next.hour    = wr.data[5:0]; // RULE1 RULE2 RULE3
        `RTCC_OFS_WEEKDAY: cal_next.weekday = wr.data[2:0]; // RULE4
        `RTCC_OFS_DATE:    cal_next.date    = wr.data[5:0]; // RULE6 RULE7
        `RTCC_OFS_MONTH:   cal_next.month   = wr.data[4:0]; // RULE8
        default:           cal_next         = cal_next;
      endcase
    end
    if (wr_alarm_config_page) begin
      unique case (wr.addr)
        `RTCC_OFS_HOUR:    alarm_next.hour    = wr.data[5:0]; // RULE5
        `RTCC_OFS_WEEKDAY: alarm_next.weekday = wr.data[2:0]; // RULE5
        `RTCC_OFS_DATE:    alarm_next.date    = wr.data[5:0]; // RULE5
        default:           alarm_next         = alarm_reg;
      endcase
    end
  end

  // no reset: contents are unknown until software loads them
  always_ff @(posedge i_clk) begin
    cal_reg   <= cal_next; // RULE11
    alarm_reg <= alarm_next; // RULE11
  end

  // one-cycle pulse when a counted hour lands on the page 1 settings
  always_comb begin
    alarm_hit_next = tick
                  && cal_stepped.hour == alarm_reg.hour
                  && cal_stepped.weekday == alarm_reg.weekday
                  && cal_stepped.date == alarm_reg.date;
  end

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      alarm_hit_reg <= 1'b0;
    end else begin
      alarm_hit_reg <= alarm_hit_next;
    end
  end

endmodule : rtcc_top
`default_nettype wire

// file: bench/rtcc_top_assertions.sv
`timescale 1ns/1ns
`default_nettype none
`include "rtcc_map.svh"
module rtcc_top_assertions (
  input wire logic        i_clk,
  input wire logic        i_arst_n,
  input wire logic        i_awvalid,
  input wire logic        o_awready,
  input wire logic        i_wvalid,
  input wire logic        o_wready,
  input wire logic [1:0]  o_bresp,
  input wire logic        o_bvalid,
  input wire logic        i_bready,
  input wire logic [11:0] i_araddr,
  input wire logic        i_arvalid,
  input wire logic        o_arready,
  input wire logic [31:0] o_rdata,
  input wire logic [1:0]  o_rresp,
  input wire logic        o_rvalid,
  input wire logic        i_rready
);
  logic [11:0] rd_addr_reg;
  logic [11:0] rd_addr_next;
  // remembers which register the pending read points at
  always_comb begin
    rd_addr_next = rd_addr_reg;
    if (i_arvalid && o_arready) rd_addr_next = i_araddr;
  end
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) rd_addr_reg <= 12'h000;
    else rd_addr_reg <= rd_addr_next;
  end
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_arst_n);
  a_write_answer_time: assert property (i_awvalid && o_awready && i_wvalid && o_wready
    |=> !o_awready && !o_wready ##1 o_bvalid) else $error("write answer timing");
  a_read_answer_time: assert property (i_arvalid && o_arready |=> o_rvalid)
    else $error("read answer timing");
  a_bresp_holds: assert property (o_bvalid && !i_bready |=> o_bvalid && $stable(o_bresp))
    else $error("write response dropped");
  a_rdata_holds: assert property (o_rvalid && !i_rready |=> o_rvalid && $stable(o_rdata))
    else $error("read data dropped");
  a_bvalid_clears: assert property (o_bvalid && i_bready |=> !o_bvalid)
    else $error("bvalid stuck");
  a_rvalid_clears: assert property (o_rvalid && i_rready |=> !o_rvalid)
    else $error("rvalid stuck");
  a_arready_excl: assert property (o_arready != o_rvalid) else $error("arready wrong");
  a_slverr_zero_data: assert property (o_rvalid && o_rresp == `RTCC_RESP_SLVERR
    |-> o_rdata == 32'h0) else $error("error read data not zero");
  a_hour_upper_zero: assert property (o_rvalid && rd_addr_reg == `RTCC_OFS_HOUR
    |-> o_rdata[31:6] == 26'h0) else $error("hour upper bits");
  a_weekday_upper_zero: assert property (o_rvalid && rd_addr_reg == `RTCC_OFS_WEEKDAY
    |-> o_rdata[31:3] == 29'h0) else $error("weekday upper bits");
  a_date_upper_zero: assert property (o_rvalid && rd_addr_reg == `RTCC_OFS_DATE
    |-> o_rdata[31:6] == 26'h0) else $error("date upper bits");
  a_month_upper_zero: assert property (o_rvalid && rd_addr_reg == `RTCC_OFS_MONTH
    |-> o_rdata[31:5] == 27'h0) else $error("month upper bits");
endmodule : rtcc_top_assertions

bind rtcc_top rtcc_top_assertions chk_u (.i_clk, .i_arst_n, .i_awvalid, .o_awready,
  .i_wvalid, .o_wready, .o_bresp, .o_bvalid, .i_bready, .i_araddr, .i_arvalid,
  .o_arready, .o_rdata, .o_rresp, .o_rvalid, .i_rready);
`default_nettype wire

// file: bench/tb_rtcc_top.sv
`timescale 1ns/1ns
`default_nettype none
`include "rtcc_map.svh"
module tb_rtcc_top;
  localparam logic [11:0] A_HR = `RTCC_OFS_HOUR;
  localparam logic [11:0] A_WD = `RTCC_OFS_WEEKDAY;
  localparam logic [11:0] A_DT = `RTCC_OFS_DATE;
  localparam logic [11:0] A_MO = `RTCC_OFS_MONTH;
  localparam logic [11:0] A_PG = `RTCC_OFS_PAGE_CTRL;
  localparam logic [1:0]  OK   = `RTCC_RESP_OKAY;
  localparam logic [1:0]  SE   = `RTCC_RESP_SLVERR;
  logic        i_clk, i_arst_n, i_awvalid, i_wvalid, i_bready, i_arvalid, i_rready;
  logic        i_hour_carry, i_leap_year;
  logic [11:0] i_awaddr, i_araddr;
  logic [31:0] i_wdata, o_rdata;
  logic [3:0]  i_wstrb;
  logic        o_awready, o_wready, o_bvalid, o_arready, o_rvalid, o_alarm_hit;
  logic [1:0]  o_bresp, o_rresp;
  int          failures, num_checks, cyc;

  rtcc_top dut_u (.i_clk, .i_arst_n, .i_awaddr, .i_awvalid, .o_awready, .i_wdata,
    .i_wstrb, .i_wvalid, .o_wready, .o_bresp, .o_bvalid, .i_bready, .i_araddr,
    .i_arvalid, .o_arready, .o_rdata, .o_rresp, .o_rvalid, .i_rready,
    .i_hour_carry, .i_leap_year, .o_alarm_hit);

  initial begin
    i_clk = 1'b0;
    forever #2 i_clk = ~i_clk;
  end

  always @(posedge i_clk) begin
    cyc++;
    if (cyc == 5000) begin
      failures++;
      print_verdict();
    end
  end

  task automatic print_verdict;
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : print_verdict

  task automatic check_data(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      failures++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check_data

  task automatic check_resp(input logic [1:0] got, input logic [1:0] exp);
    num_checks++;
    if (got !== exp) begin
      failures++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check_resp

  task automatic check_flag(input logic got, input logic exp);
    num_checks++;
    if (got !== exp) begin
      failures++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check_flag

  // response ready is raised only after valid is seen, to exercise the stall
  task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er);
    logic done;
    done = 1'b0;
    @(posedge i_clk);
    i_awaddr <= a;
    i_wdata <= d;
    i_awvalid <= 1'b1;
    i_wvalid <= 1'b1;
    while (!done) begin
      @(posedge i_clk);
      if (i_awvalid && o_awready) i_awvalid <= 1'b0;
      if (i_wvalid && o_wready) i_wvalid <= 1'b0;
      if (o_bvalid && i_bready) begin
        check_resp(o_bresp, er);
        done = 1'b1;
      end
      if (o_bvalid) i_bready <= ~i_bready;
    end
  endtask : wr

  task automatic rd(input logic [11:0] a, input logic [31:0] ed, input logic [1:0] er);
    logic done;
    done = 1'b0;
    @(posedge i_clk);
    i_araddr <= a;
    i_arvalid <= 1'b1;
    while (!done) begin
      @(posedge i_clk);
      if (i_arvalid && o_arready) i_arvalid <= 1'b0;
      if (o_rvalid && i_rready) begin
        check_data(o_rdata, ed);
        check_resp(o_rresp, er);
        done = 1'b1;
      end
      if (o_rvalid) i_rready <= ~i_rready;
    end
  endtask : rd

  task automatic tick;
    @(posedge i_clk);
    i_hour_carry <= 1'b1;
    @(posedge i_clk);
    i_hour_carry <= 1'b0;
  endtask : tick

  task automatic t_format;
    wr(A_PG, 32'h01, OK);
    rd(A_MO, 32'h01, OK);
    wr(A_MO, 32'hfe, OK);
    rd(A_MO, 32'h00, OK);
    wr(A_MO, 32'hff, OK);
    rd(A_MO, 32'h01, OK);
  endtask : t_format

  task automatic t_pages;
    logic [11:0] ad[4];
    logic [31:0] wv[4];
    logic [31:0] ev[4];
    ad = '{A_HR, A_WD, A_DT, A_MO};
    wv = '{32'hffffffe3, 32'hf5, 32'hd9, 32'hf2};
    ev = '{32'h23, 32'h05, 32'h19, 32'h12};
    wr(A_HR, 32'h07, OK);
    wr(A_WD, 32'h02, OK);
    wr(A_DT, 32'h15, OK);
    wr(A_PG, 32'h00, OK);
    for (int i = 0; i < 4; i++) wr(ad[i], wv[i], OK);
    for (int i = 0; i < 4; i++) rd(ad[i], ev[i], OK);
    wr(A_PG, 32'h01, OK);
    rd(A_HR, 32'h07, OK);
    rd(A_WD, 32'h02, OK);
    rd(A_DT, 32'h15, OK);
    rd(A_MO, 32'h01, OK);
    wr(A_PG, 32'h00, OK);
  endtask : t_pages

  task automatic t_count24;
    wr(A_HR, 32'h09, OK);
    wr(A_PG, 32'h08, OK);
    tick();
    rd(A_HR, 32'h10, OK);
    wr(A_HR, 32'h23, OK);
    wr(A_WD, 32'h06, OK);
    wr(A_DT, 32'h31, OK);
    wr(A_MO, 32'h12, OK);
    tick();
    rd(A_HR, 32'h00, OK);
    rd(A_WD, 32'h00, OK);
    rd(A_DT, 32'h01, OK);
    rd(A_MO, 32'h01, OK);
  endtask : t_count24

  task automatic t_count12;
    wr(A_PG, 32'h01, OK);
    wr(A_MO, 32'h00, OK);
    wr(A_PG, 32'h00, OK);
    wr(A_HR, 32'h11, OK);
    wr(A_WD, 32'h03, OK);
    wr(A_DT, 32'h05, OK);
    wr(A_MO, 32'h02, OK);
    wr(A_PG, 32'h08, OK);
    tick();
    rd(A_HR, 32'h20, OK);
    rd(A_DT, 32'h05, OK);
    wr(A_HR, 32'h31, OK);
    tick();
    rd(A_HR, 32'h00, OK);
    rd(A_WD, 32'h04, OK);
    rd(A_DT, 32'h06, OK);
  endtask : t_count12

  // 12-hour AM 06 steps to 07 and lands on the page 1 settings 07 / 2 / 15
  task automatic t_alarm;
    wr(A_HR, 32'h06, OK);
    wr(A_WD, 32'h02, OK);
    wr(A_DT, 32'h15, OK);
    tick();
    @(posedge i_clk);
    check_flag(o_alarm_hit, 1'b1);
    @(posedge i_clk);
    check_flag(o_alarm_hit, 1'b0);
    rd(A_HR, 32'h07, OK);
  endtask : t_alarm

  task automatic t_leap;
    wr(A_HR, 32'h31, OK);
    wr(A_DT, 32'h28, OK);
    i_leap_year <= 1'b1;
    tick();
    rd(A_DT, 32'h29, OK);
    rd(A_MO, 32'h02, OK);
    i_leap_year <= 1'b0;
    wr(A_HR, 32'h31, OK);
    wr(A_DT, 32'h28, OK);
    tick();
    rd(A_DT, 32'h01, OK);
    rd(A_MO, 32'h03, OK);
    rd(A_PG, 32'h08, OK);
  endtask : t_leap

  task automatic t_unmapped;
    wr(12'h100, 32'h5a, SE);
    rd(12'h100, 32'h00, SE);
  endtask : t_unmapped

  initial begin
    {i_arst_n, i_awvalid, i_wvalid, i_bready, i_arvalid, i_rready} = 6'h00;
    {i_hour_carry, i_leap_year} = 2'h0;
    i_awaddr = 12'h000;
    i_araddr = 12'h000;
    i_wdata = 32'h0;
    i_wstrb = 4'hf;
    repeat (3) @(posedge i_clk);
    i_arst_n <= 1'b1;
    t_format();
    t_pages();
    t_count24();
    t_count12();
    t_alarm();
    t_leap();
    t_unmapped();
    repeat (4) @(posedge i_clk);
    print_verdict();
  end
endmodule : tb_rtcc_top
`default_nettype wire
